// File: flts_pkg.sv
package flts_pkg;

   // ----------------------------------------------------------------
   // Register map (APB byte offsets)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_STATUS  = 12'h004;
   localparam logic [11:0] ADDR_CWORD   = 12'h008;
   localparam logic [11:0] ADDR_MSAR    = 12'h00c;
   localparam logic [11:0] ADDR_RESULT  = 12'h010;
   localparam logic [11:0] ADDR_IDS     = 12'h014;

   // ----------------------------------------------------------------
   // Control register bits
   // ----------------------------------------------------------------
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_RESTART = 1;
   localparam int CTRL_SEARCH  = 2;

   // ----------------------------------------------------------------
   // Scan and test constants
   // ----------------------------------------------------------------
   localparam logic [4:0] SEQ_FIRST     = 5'h07;
   localparam logic [4:0] SEQ_CWORD     = 5'h01;
   localparam logic [4:0] SEQ_NOSAMPLE  = 5'h02;
   localparam logic [4:0] SEQ_IDWORD    = 5'h08;
   localparam logic [4:0] SEQ_HW_MIN    = 5'h0e;
   localparam logic [4:0] RETRY_INIT    = 5'h1f;
   localparam logic [2:0] WORD_CWORD    = 3'h1;
   localparam logic [2:0] WORD_LAST     = 3'h0;

   // Field positions, numbered with bit 0 as the most significant bit.
   localparam int CW_HI  = 32;
   localparam int MS_HI  = 40;
   localparam int MS_LO  = 51;
   localparam int SEQ_HI = 53;
   localparam int CNT_HI = 58;
   localparam int CNT_LO = 61;

   // Control word bits, bit 0 most significant, 8-bit image of word bits 32-39.
   localparam int CWB_HALF = 4;
   localparam int CWB_UNC  = 5;
   localparam int CWB_CND  = 6;
   localparam int CWB_EXP  = 7;

   typedef enum {
      ST_IDLE, ST_REQ, ST_WAIT, ST_CHECK, ST_LAST, ST_CYCLE, ST_HALT, ST_SYNC,
      ST_SCANOUT, ST_MASK, ST_COMPARE, ST_DECIDE, ST_STOP, ST_EXHAUST
   } flts_state_t;

endpackage : flts_pkg

// File: flts_top.sv
`timescale 1ns/1ps
module flts_top
   import flts_pkg::*;
#(
   parameter int AW = 16
)(
   // APB slave
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // Channel signals (asynchronous pins)
   input  wire logic            buffer_full_pulse,
   input  wire logic            gap_pulse,
   output logic                 start_scan_req,
   output logic                 stop_scan_req,
   // Storage read port, single cycle latency
   output logic                 stor_req,
   output logic      [AW-1:0]   stor_addr,
   input  wire logic [63:0]     stor_rdata,
   input  wire logic            stor_err,
   // Processor side
   output logic                 proc_clk_run,
   output logic      [11:0]     microstore_address_reg,
   input  wire logic [63:0]     scanout_word,
   output logic      [4:0]      scanout_sel,
   output logic                 scanout_hw,
   output logic                 scanout_ucode
);

   // ----------------------------------------------------------------
   // Buffer bases and helpers
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] BUF1_BASE = AW'(16'h8000);
   localparam logic [AW-1:0] BUF2_BASE = AW'(16'h8080);
   localparam logic [AW-1:0] MASK_OFS  = AW'(16'h0048);

   // Word address within a buffer: eight bytes per doubleword.
   function automatic logic [AW-1:0] word_addr(input logic buf_sel, input logic [4:0] idx);
      word_addr = (buf_sel ? BUF2_BASE : BUF1_BASE) + AW'({idx, 3'h0});
   endfunction : word_addr

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] bfp_s_q, gap_s_q;
   logic       bfp_d_q, gap_d_q;
   logic       fill_ev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bfp_s_q <= 2'h0;
         gap_s_q <= 2'h0;
         bfp_d_q <= 1'b0;
         gap_d_q <= 1'b0;
      end else begin
         bfp_s_q <= {bfp_s_q[0], buffer_full_pulse};
         gap_s_q <= {gap_s_q[0], gap_pulse};
         bfp_d_q <= bfp_s_q[1];
         gap_d_q <= gap_s_q[1];
      end
   end

   assign fill_ev = (bfp_s_q[1] & ~bfp_d_q) | (gap_s_q[1] & ~gap_d_q);

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   flts_state_t state_q;
   logic [4:0]  seq_q;
   logic [4:0]  retry_q;
   logic [5:0]  cyc_q;
   logic [7:0]  cword_q;
   logic [63:0] inbound_word_reg_q;
   logic [63:0] work2_q;
   logic [63:0] compare_result_latch_q;
   logic [31:0] ids_q;
   logic        buf_q, pend_q, err_q;
   logic        pass_q, fail_q, inter_q, alt_q, zero_q, sync_q;
   logic        clock_halt_trigger_q, scanout_control_trigger_q, cnt_trig_q;
   logic        enable_q, restart_q, search_q, match_q;
   logic [4:0]  seq_ld_q;
   logic        res_pass;
   logic        do_stop, go_alt;

   // Fields are numbered from the most significant end, so word bit k sits at 63-k.
   // An all-ones OR of scan-out word and mask means the exit trigger is set.
   assign res_pass = (&(compare_result_latch_q | work2_q)) == cword_q[7-CWB_EXP];

   // Decision table, bit numbers refer to the control word image.
   always_comb begin
      do_stop = (cword_q[7-CWB_CND] & fail_q)
              | (cword_q[7-CWB_UNC] & (pass_q | fail_q));
      go_alt  = ~cword_q[7-CWB_UNC] & ~cword_q[7-CWB_CND] & pass_q & ~fail_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q                   <= ST_IDLE;
         seq_q                     <= 5'h00;
         seq_ld_q                  <= 5'h00;
         retry_q                   <= RETRY_INIT;
         cyc_q                     <= 6'h00;
         cword_q                   <= 8'h00;
         inbound_word_reg_q        <= 64'h0;
         work2_q                   <= 64'h0;
         compare_result_latch_q    <= 64'h0;
         microstore_address_reg    <= 12'h000;
         ids_q                     <= 32'h0;
         buf_q                     <= 1'b0;
         pend_q                    <= 1'b0;
         err_q                     <= 1'b0;
         pass_q                    <= 1'b0;
         fail_q                    <= 1'b0;
         inter_q                   <= 1'b0;
         alt_q                     <= 1'b0;
         zero_q                    <= 1'b0;
         sync_q                    <= 1'b0;
         clock_halt_trigger_q      <= 1'b1;
         scanout_control_trigger_q <= 1'b0;
         cnt_trig_q                <= 1'b0;
         start_scan_req            <= 1'b0;
         stop_scan_req             <= 1'b0;
         match_q                   <= 1'b0;
      end else begin
         start_scan_req <= 1'b0;
         stop_scan_req  <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (enable_q && fill_ev) begin
                  seq_q   <= SEQ_FIRST;
                  state_q <= ST_REQ;
               end
            end
            ST_REQ: begin
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               inbound_word_reg_q <= stor_rdata;
               err_q              <= stor_err;
               if (seq_q == SEQ_CWORD) begin
                  cword_q    <= stor_rdata[63-CW_HI -: 8];
                  cyc_q      <= {2'h0, stor_rdata[63-CNT_HI -: 4]};
                  seq_ld_q   <= stor_rdata[63-SEQ_HI -: 5];
                  cnt_trig_q <= 1'b1;
               end
               if (seq_q == {2'h0, WORD_LAST}) begin
                  // The sequencer still walks the words until word 0 is in, so the
                  // scan-out selector held from word 1 takes over only here.
                  // Halting first makes every test run exactly the loaded count.
                  seq_q                <= seq_ld_q;
                  clock_halt_trigger_q <= 1'b1;
                  state_q              <= ST_CYCLE;
               end else begin
                  seq_q   <= seq_q - 5'h01;
                  state_q <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (err_q) begin
                  if (retry_q == 5'h00)
                     state_q <= ST_EXHAUST;
                  else begin
                     retry_q        <= retry_q - 5'h01;
                     start_scan_req <= 1'b1;
                     seq_q          <= SEQ_FIRST;
                     cnt_trig_q     <= 1'b0;
                     state_q        <= ST_IDLE;
                  end
               end else if (pend_q && seq_q != SEQ_NOSAMPLE) begin
                  pend_q  <= 1'b0;
                  seq_q   <= SEQ_IDWORD;
                  state_q <= ST_LAST;
               end else if (seq_q == {2'h0, WORD_LAST}) begin
                  microstore_address_reg <= inbound_word_reg_q[63-MS_LO +: 12];
                  state_q                <= ST_REQ;
               end else
                  state_q <= ST_REQ;
            end
            ST_CYCLE: begin
               if (cyc_q == 6'h00) begin
                  zero_q                    <= 1'b1;
                  scanout_control_trigger_q <= 1'b1;
                  clock_halt_trigger_q      <= 1'b1;
                  sync_q                    <= 1'b1;
                  state_q                   <= ST_SYNC;
               end else begin
                  clock_halt_trigger_q <= 1'b0;
                  cyc_q                <= cyc_q - 6'h01;
               end
            end
            ST_SYNC: begin
               clock_halt_trigger_q <= 1'b0;
               sync_q               <= 1'b0;
               state_q              <= ST_SCANOUT;
            end
            ST_SCANOUT: begin
               compare_result_latch_q <= scanout_word;
               state_q                <= ST_MASK;
            end
            ST_MASK: begin
               work2_q <= stor_rdata;
               state_q <= ST_COMPARE;
            end
            ST_COMPARE: begin
               if (res_pass)
                  pass_q <= 1'b1;
               else
                  fail_q <= 1'b1;
               // A repeated test may pass once and fail once; both set marks it.
               inter_q <= inter_q | ((pass_q | res_pass) & (fail_q | ~res_pass));
               scanout_control_trigger_q <= 1'b0;
               zero_q                    <= 1'b0;
               seq_q                     <= pend_q ? SEQ_IDWORD : SEQ_FIRST;
               state_q                   <= pend_q ? ST_LAST : ST_REQ;
               pend_q                    <= 1'b0;
            end
            ST_LAST: begin
               state_q <= ST_DECIDE;
            end
            ST_DECIDE: begin
               inbound_word_reg_q <= stor_rdata;
               ids_q              <= stor_rdata[31:0];
               match_q <= (restart_q | search_q) &&
                          (stor_rdata[63:32] == ~ids_q);
               buf_q <= ~buf_q;
               if (do_stop) begin
                  alt_q          <= 1'b1;
                  stop_scan_req  <= 1'b1;
                  cword_q[7-CWB_UNC] <= 1'b1;
                  state_q        <= ST_STOP;
               end else begin
                  alt_q   <= go_alt;
                  seq_q   <= SEQ_FIRST;
                  state_q <= ST_REQ;
               end
            end
            ST_STOP: begin
               clock_halt_trigger_q <= 1'b1;
               if (restart_q) begin
                  pass_q  <= 1'b1;
                  fail_q  <= 1'b0;
                  retry_q <= RETRY_INIT;
                  state_q <= ST_IDLE;
               end
            end
            ST_EXHAUST: begin
               clock_halt_trigger_q <= 1'b1;
               if (restart_q) begin
                  retry_q <= RETRY_INIT;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         // Kept after the state logic so a new pulse wins over clearing an old one.
         if (fill_ev && state_q != ST_IDLE)
            pend_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Processor and storage outputs
   // ----------------------------------------------------------------
   assign proc_clk_run  = ~clock_halt_trigger_q & (state_q == ST_CYCLE);
   assign stor_req      = (state_q == ST_REQ) | (state_q == ST_SCANOUT) | (state_q == ST_LAST);
   assign stor_addr     = (state_q == ST_SCANOUT) ? word_addr(buf_q, 5'h00) + MASK_OFS
                                                  : word_addr(buf_q, seq_q);
   assign scanout_sel   = seq_q;
   assign scanout_hw    = scanout_control_trigger_q & (seq_q >= SEQ_HW_MIN);
   assign scanout_ucode = scanout_control_trigger_q & (seq_q < SEQ_HW_MIN);

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic wr;
   assign wr      = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q  <= 1'b0;
         restart_q <= 1'b0;
         search_q  <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         if (wr && paddr == ADDR_CTRL) begin
            enable_q  <= pwdata[CTRL_ENABLE];
            restart_q <= pwdata[CTRL_RESTART];
            search_q  <= pwdata[CTRL_SEARCH];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite) begin
         case (paddr)
            ADDR_CTRL:   prdata <= {29'h0, search_q, 1'b0, enable_q};
            ADDR_STATUS: prdata <= {11'h0, retry_q, 4'h0, buf_q, match_q, alt_q,
                                    inter_q, fail_q, pass_q, zero_q, sync_q,
                                    clock_halt_trigger_q, scanout_control_trigger_q,
                                    cnt_trig_q, 1'b0};
            ADDR_CWORD:  prdata <= {18'h0, cyc_q, cword_q};
            ADDR_MSAR:   prdata <= {15'h0, seq_q, microstore_address_reg};
            ADDR_RESULT: prdata <= compare_result_latch_q[31:0];
            ADDR_IDS:    prdata <= ids_q;
            default:     prdata <= 32'h0;
         endcase
      end
   end

endmodule : flts_top

// File: flts_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks of the test sequencer
// ----------------------------------------------------------------
module flts_chk
   import flts_pkg::*;
#(
   parameter int AW = 16
)(
   // Clock and reset
   input wire logic          pclk,
   input wire logic          presetn,
   // Channel and storage
   input wire logic          start_scan_req,
   input wire logic          stop_scan_req,
   input wire logic          stor_req,
   input wire logic [AW-1:0] stor_addr,
   input wire logic          stor_err,
   // Processor side
   input wire logic          proc_clk_run,
   input wire logic [4:0]    scanout_sel,
   input wire logic          scanout_hw,
   input wire logic          scanout_ucode
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_req_spacing: assert property (stor_req |=> !stor_req)
      else $error("storage request held two cycles");
   a_addr_window: assert property (stor_req |-> stor_addr[15:7] == 9'h100 || stor_addr[15:7] == 9'h101)
      else $error("storage request outside the test buffers");
   a_err_backspace: assert property (stor_req && stor_addr[6:0] < 7'h40 ##1 stor_err |-> ##[0:6] start_scan_req)
      else $error("scan input error without backspace request");
   a_scan_pulse: assert property (start_scan_req |=> !start_scan_req)
      else $error("backspace request longer than one cycle");
   a_stop_pulse: assert property (stop_scan_req |=> !stop_scan_req)
      else $error("stop request longer than one cycle");
   a_hw_scanout: assert property (scanout_hw |-> scanout_sel >= SEQ_HW_MIN)
      else $error("hardware scan-out below word 14");
   a_ucode_scanout: assert property (scanout_ucode |-> scanout_sel < SEQ_HW_MIN)
      else $error("microprogram scan-out above word 13");
   a_halt_quiet: assert property ($fell(proc_clk_run) |-> !proc_clk_run [*8])
      else $error("processor clock restarted right after halt");
   c_backspace: cover property (start_scan_req);
   c_stop: cover property (stop_scan_req);
   c_hw: cover property (scanout_hw);
endmodule : flts_chk

bind flts_top flts_chk #(.AW(AW)) flts_chk_i (
   .pclk(pclk), .presetn(presetn), .start_scan_req(start_scan_req),
   .stop_scan_req(stop_scan_req), .stor_req(stor_req), .stor_addr(stor_addr),
   .stor_err(stor_err), .proc_clk_run(proc_clk_run), .scanout_sel(scanout_sel),
   .scanout_hw(scanout_hw), .scanout_ucode(scanout_ucode)
);

// File: flts_chan.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Channel model: two test buffers in storage, fill pulses, backspace
// ----------------------------------------------------------------
module flts_chan #(
   parameter int AW = 16
)(
   // Clock and bench commands
   input  wire logic          pclk,
   input  wire logic          fill_go,
   input  wire logic          err_go,
   // Storage read port
   input  wire logic          stor_req,
   input  wire logic [AW-1:0] stor_addr,
   output logic      [63:0]   stor_rdata,
   output logic               stor_err,
   // Channel pins
   input  wire logic          start_scan_req,
   input  wire logic          stop_scan_req,
   output logic               buffer_full_pulse,
   output logic               gap_pulse
);
   logic [63:0] mem [0:31];
   logic        err_arm = 1'b0;
   logic        halted  = 1'b0;
   int          refill  = 0;
   int          pulse   = 0;
   initial begin
      stor_rdata = 64'h0;
      stor_err = 1'b0;
      buffer_full_pulse = 1'b0;
      gap_pulse = 1'b0;
   end
   // Read data stands one cycle only; it flips afterwards so a late sample shows.
   always @(posedge pclk) begin
      stor_err <= 1'b0;
      stor_rdata <= ~stor_rdata;
      if (err_go) err_arm <= 1'b1;
      if (stor_req) begin
         stor_rdata <= mem[stor_addr[7:3]];
         if (err_arm && stor_addr[6:3] == 4'h5) begin
            stor_err <= 1'b1;
            err_arm <= 1'b0;
         end
      end
   end
   // A backspace rereads the record, so the fill pulse comes again after a delay.
   always @(posedge pclk) begin
      if (stop_scan_req) halted <= 1'b1;
      if (start_scan_req && !halted) refill <= 30;
      else if (refill > 0) refill <= refill - 1;
      if (fill_go || refill == 1) pulse <= 4;
      else if (pulse > 0) pulse <= pulse - 1;
      buffer_full_pulse <= (pulse > 0);
   end
endmodule : flts_chan

// File: flts_top_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the test sequencer
// ----------------------------------------------------------------
module flts_top_test;
   import flts_pkg::*;
   localparam int          AW    = 16;
   localparam logic [11:0] MS_V  = 12'h5a3;
   localparam logic [4:0]  SEQ_V = 5'h10;
   localparam logic [3:0]  CNT_V = 4'h3;
   typedef struct {
      logic [31:0] exp;
      logic [31:0] msk;
   } flts_note_t;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, fill_go, err_go;
   logic          buffer_full_pulse, gap_pulse, start_scan_req, stop_scan_req;
   logic          stor_req, stor_err, proc_clk_run, scanout_hw, scanout_ucode;
   logic [11:0]   paddr, microstore_address_reg;
   logic [31:0]   pwdata, prdata, rd;
   logic [AW-1:0] stor_addr;
   logic [63:0]   stor_rdata, scan_w;
   logic [4:0]    scanout_sel;
   flts_note_t    notes [$];
   flts_note_t    note;
   int            fails, cmp_count, seed, n, cnt;
   wire  [3:0]    hits = {stor_req & stor_addr[7], proc_clk_run, stop_scan_req, start_scan_req};
   flts_top #(.AW(AW)) flts_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .buffer_full_pulse(buffer_full_pulse), .gap_pulse(gap_pulse),
      .start_scan_req(start_scan_req), .stop_scan_req(stop_scan_req), .stor_req(stor_req),
      .stor_addr(stor_addr), .stor_rdata(stor_rdata), .stor_err(stor_err),
      .proc_clk_run(proc_clk_run), .microstore_address_reg(microstore_address_reg),
      .scanout_word(scan_w), .scanout_sel(scanout_sel), .scanout_hw(scanout_hw),
      .scanout_ucode(scanout_ucode));
   flts_chan #(.AW(AW)) flts_chan_i (
      .pclk(pclk), .fill_go(fill_go), .err_go(err_go), .stor_req(stor_req),
      .stor_addr(stor_addr), .stor_rdata(stor_rdata), .stor_err(stor_err),
      .start_scan_req(start_scan_req), .stop_scan_req(stop_scan_req),
      .buffer_full_pulse(buffer_full_pulse), .gap_pulse(gap_pulse));
   always #12.5 pclk = ~pclk;
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      cmp_count++;
      if ((got & m) !== (exp & m)) begin
         fails++;
         $display("ERROR %0t value %h expected %h under mask %h", $time, got, exp, m);
      end
   endtask : cmp_word
   task automatic cmp_pin(input logic got, input int k);
      cmp_count++;
      if (got !== 1'b1) begin
         fails++;
         $display("ERROR %0t awaited event %0d did not come", $time, k);
      end
   endtask : cmp_pin
   // Reads leave a note for the monitor; a zero mask marks a polling read.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m);
      if (!wr) notes.push_back('{e, m});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) cmp_word(32'h0, 32'h1, 32'h1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic poll(input int b);
      rd = 32'h0;
      for (int i = 0; i < 60 && rd[b] !== 1'b1; i++) apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 32'h0);
   endtask : poll
   task automatic wait_on(input int k, input int lim);
      n = 0;
      while (hits[k] !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      cmp_pin(hits[k], k);
   endtask : wait_on
   task automatic kick(input logic err);
      err_go <= err;
      fill_go <= 1'b1;
      @(posedge pclk);
      err_go <= 1'b0;
      fill_go <= 1'b0;
      @(posedge pclk);
   endtask : kick
   task automatic load_buf(input int b, input logic [7:0] cw);
      for (int i = 0; i < 10; i++) flts_chan_i.mem[b*16+i] = {$random(seed), $random(seed)};
      flts_chan_i.mem[b*16+1][31:2] = {cw, MS_V, 1'b0, SEQ_V, CNT_V};
      flts_chan_i.mem[b*16+9] = 64'hffff_ffff_ffff_fffe;
   endtask : load_buf
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
         note = notes.pop_front();
         if (note.msk !== 32'h0) cmp_word(prdata, note.exp, note.msk);
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      $display("ERROR %0t run did not finish in time", $time);
      give_verdict();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, fill_go, err_go} = 7'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      fails = 0;
      cmp_count = 0;
      seed = 32'hecb0;
      scan_w = {$random(seed), $random(seed)} | 64'h1;
      load_buf(0, 8'h01);
      load_buf(1, 8'h05);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h001f_0008, 32'h001f_0008);
      apb(1'b0, 12'h0ff, 32'h0, 32'h0, 32'hffff_ffff);
      apb(1'b1, ADDR_CTRL, 32'h1, 32'h0, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0, 32'h1, 32'h1);
      $display("test registers done");
      kick(1'b1);
      wait_on(0, 400);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h001e_0000, 32'h001f_0000);
      $display("test scan error done");
      wait_on(2, 600);
      cmp_word({20'h0, microstore_address_reg}, {20'h0, MS_V}, 32'hfff);
      cmp_word({27'h0, scanout_sel}, {27'h0, SEQ_V}, 32'h1f);
      cnt = 0;
      while (proc_clk_run === 1'b1 && cnt < 70) begin
         cnt++;
         @(posedge pclk);
      end
      cmp_word(32'(cnt), {28'h0, CNT_V}, 32'hff);
      poll(6);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h40, 32'hc0);
      apb(1'b0, ADDR_CWORD, 32'h0, 32'h01, 32'hff);
      $display("test scan-in and pass done");
      scan_w[0] <= 1'b0;
      poll(7);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h1c0, 32'h1c0);
      scan_w[0] <= 1'b1;
      $display("test intermittent done");
      kick(1'b0);
      wait_on(3, 800);
      cmp_word({16'h0, stor_addr}, 32'h80b8, 32'hffff);
      wait_on(2, 800);
      poll(6);
      kick(1'b0);
      wait_on(1, 800);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h200, 32'h200);
      $display("test stop decision done");
      give_verdict();
   end
endmodule : flts_top_test
